// *** core/gpoexp_regs.vh ***
`ifndef GPOEXP_REGS_VH
`define GPOEXP_REGS_VH
// Bus addresses and general call software reset byte
`define GPOEXP_SLAVE_ADDR 7'h48
`define GPOEXP_GCALL_ADDR 7'h00
`define GPOEXP_SWRST_BYTE 8'h06
// Output register reset value and read-back filler
`define GPOEXP_OUT_RESET 4'hF
`define GPOEXP_UPPER_FILL 4'hF
// Sampler depth for SCL/SDA
`define GPOEXP_SYNC_LEN 2
`endif

// *** core/gpoexp_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module gpoexp_sync (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Raw level in, settled level out
  input wire din,
  output reg dout
);
  reg meta_r;

  // Two-stage synchroniser, idles high like the bus
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // gpoexp_sync
`default_nettype wire

// *** core/gpoexp_top.v ***
`include "gpoexp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module gpoexp_top (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // I2C bus, open drain data
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // Output port lines
  output reg out_line_0,
  output reg out_line_1,
  output reg out_line_2,
  output reg out_line_3,
  // Sensed pin levels
  input wire [3:0] pin_level
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_GCALL = 3'h4;
  localparam [2:0] ST_GDONE = 3'h5;

  wire scl_s;
  wire sda_s;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg ack_phase_r;
  reg ack_drive_r;
  reg [3:0] out_r;
  reg [3:0] pend_r;
  reg pend_vld_r;
  reg rst_pend_r;
  reg mack_r;

  gpoexp_sync u_sync_scl (
    .clk(clk),
    .rst_b(rst_b),
    .din(scl_i),
    .dout(scl_s)
  );
  gpoexp_sync u_sync_sda (
    .clk(clk),
    .rst_b(rst_b),
    .din(sda_i),
    .dout(sda_s)
  );

  // Bus condition decode
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [7:0] byte_in = {shift_r[6:0], sda_s};
  wire byte_done = scl_rise & ~ack_phase_r & (bit_cnt_r == 4'h7);
  // Fresh pin image with ones in the upper nibble
  wire [7:0] pin_byte = {`GPOEXP_UPPER_FILL, pin_level};

  // History of synchronised lines
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Bus state machine and output register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'hFF;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      out_r <= `GPOEXP_OUT_RESET;
      pend_r <= 4'h0;
      pend_vld_r <= 1'b0;
      rst_pend_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_c) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      pend_vld_r <= 1'b0;
      rst_pend_r <= 1'b0; // Repeated start cancels software reset
    end else if (stop_c) begin
      if (rst_pend_r) begin
        out_r <= `GPOEXP_OUT_RESET;
      end
      state_r <= ST_IDLE;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      pend_vld_r <= 1'b0;
      rst_pend_r <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise && !ack_phase_r) begin
        shift_r <= byte_in;
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (scl_rise && ack_phase_r) begin
        mack_r <= ~sda_s;
      end
      // Byte received: decide on acknowledge
      if (byte_done) begin
        ack_drive_r <= 1'b0;
        case (state_r)
          ST_ADDR: begin
            if (byte_in[7:1] == `GPOEXP_SLAVE_ADDR) begin
              ack_drive_r <= 1'b1;
              state_r <= byte_in[0] ? ST_RDATA : ST_WDATA;
            end else if (byte_in == {`GPOEXP_GCALL_ADDR, 1'b0}) begin
              ack_drive_r <= 1'b1;
              state_r <= ST_GCALL;
            end
          end
          ST_WDATA: begin
            ack_drive_r <= 1'b1;
            pend_r <= byte_in[3:0];
            pend_vld_r <= 1'b1;
          end
          ST_GCALL: begin
            if (byte_in == `GPOEXP_SWRST_BYTE) begin
              ack_drive_r <= 1'b1;
              rst_pend_r <= 1'b1;
            end
            state_r <= ST_GDONE;
          end
          default: begin
            ack_drive_r <= 1'b0;
          end
        endcase
      end
      // Enter or leave the acknowledge slot on falling SCL
      if (scl_fall) begin
        if (bit_cnt_r == 4'h8 && !ack_phase_r) begin
          ack_phase_r <= 1'b1;
          bit_cnt_r <= 4'h0;
          // Read keeps its address ack; data byte acks belong to the master
          if (state_r != ST_RDATA && !ack_drive_r) begin
            state_r <= ST_IDLE; // Not ours: ignore until next start
          end
          if (state_r == ST_RDATA && ack_drive_r) begin
            tx_r <= pin_byte; // First read byte after address ack
          end
        end else if (ack_phase_r) begin
          ack_phase_r <= 1'b0;
          ack_drive_r <= 1'b0;
          if (pend_vld_r) begin
            out_r <= pend_r;
            pend_vld_r <= 1'b0;
          end
          if (state_r == ST_RDATA) begin
            tx_r <= pin_byte;
            if (!mack_r && bit_cnt_r == 4'h0 && shift_r[0] == 1'b0) begin
              state_r <= ST_RDATA;
            end
          end
        end else if (state_r == ST_RDATA) begin
          tx_r <= {tx_r[6:0], 1'b1};
        end
      end
      // Master nack ends a read
      if (scl_rise && ack_phase_r && state_r == ST_RDATA && sda_s) begin
        state_r <= ST_IDLE;
      end
    end
  end

  // Drive SDA low for acks and zero read bits; lines from flops
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      out_line_0 <= 1'b1;
      out_line_1 <= 1'b1;
      out_line_2 <= 1'b1;
      out_line_3 <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      sda_oe <= (ack_phase_r & ack_drive_r) |
        ((state_r == ST_RDATA) & ~ack_phase_r & ~tx_r[7]);
      out_line_0 <= out_r[0];
      out_line_1 <= out_r[1];
      out_line_2 <= out_r[2];
      out_line_3 <= out_r[3];
    end
  end
endmodule // gpoexp_top
`default_nettype wire

// *** tb/gpoexp_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpoexp_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Port lines
  input wire logic out_line_0,
  input wire logic out_line_1,
  input wire logic out_line_2,
  input wire logic out_line_3,
  input wire logic [3:0] pin_level
);
  logic [3:0] lines;
  // Lines as one nibble
  assign lines = {out_line_3, out_line_2, out_line_1, out_line_0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Bus left idle for a while
  sequence s_idle;
    (scl_i && sda_i)[*8];
  endsequence
  AST_SDA_LOW: assert property (sda_o == 1'b0) else $error("sda_o high");
  AST_RST_LINES: assert property ($rose(rst_b) |-> lines == 4'hF) else $error("lines");
  AST_RST_OE: assert property ($rose(rst_b) |-> !sda_oe) else $error("oe reset");
  AST_OE_SCL: assert property ($changed(sda_oe) |-> !scl_i) else $error("oe scl");
  AST_OE_RISE: assert property ($rose(sda_oe) |-> $past(!scl_i, 2)) else $error("oe rise");
  AST_OE_HOLD: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("oe hold");
  AST_LINE_CHG: assert property ($changed(lines) && lines != 4'hF |-> !scl_i) else $error("chg");
  AST_IDLE: assert property (s_idle |=> $stable(lines)) else $error("idle");
endmodule // gpoexp_sva
bind gpoexp_top gpoexp_sva u_sva (.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .out_line_0(out_line_0), .out_line_1(out_line_1), .out_line_2(out_line_2),
  .out_line_3(out_line_3), .pin_level(pin_level));
`default_nettype wire

// *** tb/gpoexp_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpoexp_master (
  // Clock
  input wire logic clk,
  // Bus, sda 1 means released
  output logic scl,
  output logic sda,
  input wire logic sda_bus
);
  // Bus idle high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Wait n edges, then step off the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit slot, bus level taken at end of high phase
  task automatic bitx(input logic b, output logic r);
    w(4);
    sda = b;
    w(4);
    scl = 1'b1;
    w(7);
    r = sda_bus;
    scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    w(4);
    sda = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    sda = 1'b0;
    w(8);
    scl = 1'b0;
  endtask
  // Stop, then bus idle
  task automatic stop();
    w(4);
    sda = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda = 1'b1;
    w(8);
  endtask
  // Byte out, MSB first
  task automatic send8(input logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(d[i], x);
  endtask
  // Byte in, MSB first
  task automatic recv8(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
  endtask
endmodule // gpoexp_master
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_b, sda_oe, sda_o, r, m_scl, m_sda, sda_bus;
  logic [3:0] flip, pins, cur;
  logic [7:0] d, got, addr;
  logic [31:0] seed = 32'h5F;
  wire [3:0] lines;
  int bad_count = 0, checks_done = 0;
  // Wired-AND bus, pins seen as the lines XORed with an external flip mask
  assign sda_bus = m_sda & ~(sda_oe & ~sda_o);
  assign pins = lines ^ flip;
  gpoexp_top dut (.clk(clk), .rst_b(rst_b), .scl_i(m_scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
    .out_line_0(lines[0]), .out_line_1(lines[1]), .out_line_2(lines[2]), .out_line_3(lines[3]), .pin_level(pins));
  gpoexp_master m (.clk(clk), .scl(m_scl), .sda(m_sda), .sda_bus(sda_bus));
  // Xorshift source
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Expected acknowledge level for an address byte, 0 means acked
  function automatic logic [7:0] ack_exp(input logic [7:0] a);
    return (a[7:1] == 7'h48 || a == 8'h00) ? 8'h00 : 8'h01;
  endfunction
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    flip = 4'h0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    m.w(4);
    cur = 4'hF;
    chk({4'h0, lines}, {4'h0, cur});
    addr = 8'h90;
    m.start();
    m.send8(addr);
    m.bitx(1'b1, r);
    chk(r, ack_exp(addr));
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hF0 : xs() & 8'hFE;
      m.send8(d);
      chk({4'h0, lines}, cur);
      m.bitx(1'b1, r);
      chk(r, ack_exp(addr));
      m.w(8);
      cur = d[3:0];
      chk({4'h0, lines}, cur);
    end
    d = xs();
    flip = d[3:0];
    addr = 8'h91;
    m.start();
    m.send8(addr);
    m.bitx(1'b1, r);
    chk(r, ack_exp(addr));
    for (int i = 0; i < 3; i++) begin
      m.recv8(got);
      chk(got, {4'hF, cur ^ flip});
      d = xs();
      flip = d[3:0];
      m.bitx(i == 2, r);
    end
    m.stop();
    addr = 8'h94;
    m.start();
    m.send8(addr);
    m.bitx(1'b1, r);
    chk(r, ack_exp(addr));
    m.send8(8'h0A);
    m.stop();
    chk({4'h0, lines}, cur);
    addr = 8'h00;
    m.start();
    m.send8(addr);
    m.bitx(1'b1, r);
    chk(r, ack_exp(addr));
    m.send8(8'h06);
    m.bitx(1'b1, r);
    chk(r, ack_exp(addr));
    m.stop();
    cur = 4'hF;
    chk({4'h0, lines}, {4'h0, cur});
    end_sim();
  end
endmodule // testbench
`default_nettype wire
